// >>> hw/ccp_pkg.sv
// constants and types shared by both ends of the conditional protocol
// assumes one clock and one active-low asynchronous reset for both ends
package ccp_pkg;

  // ****************************************
  // operation word layout
  // ****************************************
  localparam int OP_LINE_HI = 15;
  localparam int OP_LINE_LO = 12;
  localparam int OP_CODE_HI = 11;
  localparam int OP_CODE_LO = 9;
  localparam int OP_FORM_HI = 8;
  localparam int OP_FORM_LO = 6;
  localparam int OP_CSEL_HI = 5;
  localparam int OP_CSEL_LO = 0;
  localparam logic [3:0] OP_LINE_PAT = 4'hf;
  // form codes; word and long codes are free choices
  localparam logic [2:0] FORM_SET = 3'h1;
  localparam logic [2:0] FORM_BRW = 3'h2;
  localparam logic [2:0] FORM_BRL = 3'h3;

  // ****************************************
  // response primitive layout
  // ****************************************
  localparam int PRIM_CA_BIT = 15;
  localparam int PRIM_FN_HI = 13;
  localparam int PRIM_FN_LO = 8;
  localparam int PRIM_IND_BIT = 0;
  localparam logic [5:0] FN_NULL = 6'h00;
  localparam logic [5:0] FN_XFER = 6'h01;
  localparam logic [5:0] FN_BUSY = 6'h02;

  // ****************************************
  // stream and byte constants
  // ****************************************
  localparam logic [31:0] WORD_BYTES = 32'h0000_0002;
  localparam logic [31:0] LONG_BYTES = 32'h0000_0004;
  localparam logic [7:0] BYTE_FALSE = 8'h00;
  localparam logic [7:0] BYTE_TRUE = 8'hff;

  typedef logic [15:0] ccp_word_t;
  typedef logic [31:0] ccp_addr_t;
  typedef logic [2:0] ccp_code_t;
  // extension word count per select code
  typedef logic [7:0][2:0] ccp_ext_tbl_t;

  // only the transfer primitive carries the come-again attribute
  function automatic logic ccp_has_ca(input logic [5:0] fn);
    return fn == FN_XFER;
  endfunction

  function automatic ccp_word_t ccp_prim(input logic ca,
                                         input logic [5:0] fn,
                                         input logic ind);
    return {ca, 1'b0, fn, 7'h00, ind};
  endfunction

endpackage

// >>> hw/ccp_if.sv
// interface registers between main processor and coprocessor
// assumes both ends share one clock; all strobes are one-cycle pulses
`timescale 1ns/1ps
interface ccp_if;
  import ccp_pkg::*;
  logic cond_wr;
  ccp_code_t cond_code;
  ccp_word_t cond_data;
  logic resp_rd;
  logic resp_valid;
  ccp_word_t resp_data;
  logic oper_wr;
  ccp_word_t oper_data;

  modport main (
    output cond_wr, cond_code, cond_data, resp_rd, oper_wr, oper_data,
    input resp_valid, resp_data
  );
  modport copro (
    input cond_wr, cond_code, cond_data, resp_rd, oper_wr, oper_data,
    output resp_valid, resp_data
  );
endinterface

// >>> hw/ccp_copro.sv
// coprocessor end: takes a selector, asks for extension words, reports
// assumes the main end reads a response only while resp_valid is high
`timescale 1ns/1ps
module ccp_copro #(
  parameter ccp_pkg::ccp_code_t SELECT_CODE = 3'h1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  ccp_if.copro bus,
  input wire logic [2:0] i_ext_need,
  input wire logic i_eval_done,
  input wire logic i_eval_true,
  output logic o_sel_valid,
  output logic [5:0] o_selector,
  output logic o_ext_valid,
  output ccp_pkg::ccp_word_t o_ext_word,
  output logic o_eval_req
);
  import ccp_pkg::*;

  // ****************************************
  // condition evaluation sequence
  // ****************************************
  typedef enum logic [1:0] {C_IDLE, C_WAIT_OPER, C_EVAL} ccp_cstate_t;
  ccp_cstate_t state;
  logic [2:0] left;

  // sequence, response register and user strobes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= C_IDLE;
      left <= 3'h0;
      bus.resp_valid <= 1'b0;
      bus.resp_data <= 16'h0000;
      o_sel_valid <= 1'b0;
      o_selector <= 6'h00;
      o_ext_valid <= 1'b0;
      o_ext_word <= 16'h0000;
      o_eval_req <= 1'b0;
    end else begin
      o_sel_valid <= 1'b0;
      o_ext_valid <= 1'b0;
      // a read consumes the posted primitive
      if (bus.resp_rd) begin
        bus.resp_valid <= 1'b0;
      end
      unique case (state)
        C_IDLE: begin
          if (bus.cond_wr && bus.cond_code == SELECT_CODE) begin
            o_selector <= bus.cond_data[OP_CSEL_HI:OP_CSEL_LO];
            o_sel_valid <= 1'b1;
            left <= i_ext_need;
            if (i_ext_need != 3'h0) begin
              bus.resp_data <= ccp_prim(1'b1, FN_XFER, 1'b0);
              bus.resp_valid <= 1'b1;
              state <= C_WAIT_OPER;
            end else begin
              o_eval_req <= 1'b1;
              state <= C_EVAL;
            end
          end
        end
        C_WAIT_OPER: begin
          if (bus.oper_wr) begin
            o_ext_word <= bus.oper_data;
            o_ext_valid <= 1'b1;
            left <= left - 3'h1;
            if (left > 3'h1) begin
              bus.resp_data <= ccp_prim(1'b1, FN_XFER, 1'b0);
              bus.resp_valid <= 1'b1;
            end else begin
              o_eval_req <= 1'b1;
              state <= C_EVAL;
            end
          end
        end
        C_EVAL: begin
          if (i_eval_done) begin
            o_eval_req <= 1'b0;
            bus.resp_data <= ccp_prim(1'b0, FN_NULL, i_eval_true);
            bus.resp_valid <= 1'b1;
            state <= C_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// >>> hw/ccp_main.sv
// main processor end of the coprocessor conditional protocol
// assumes a word fetch port answering one i_fetch_valid per request
// and a coprocessor end joined through ccp_if
//
// What this block does
// - start by writing selector to condition register
// - coprocessor decodes selector, may request services
// - coprocessor reports outcome in a null primitive
// - read response, serve it, reread on come-again
// - finish after the true/false indicator or a protocol violation
// - coprocessor sets come-again on capable primitives
// - missing come-again raises protocol violation
// - main end performs branch or byte completion
// - branch word: 1111 top, select code 11:9
// - bits 8:6 form, bits 5:0 selector
// - branch writes whole operation word
// - coprocessor extension words precede displacement
// - false branch continues sequentially
// - true branch adds displacement to scan pointer
// - scan pointer at first displacement word
// - displacement is word or long two's complement
// - word displacement sign-extended to 32 bits
// - set form writes flag byte from condition
// - set form consumes up to seven address words
// - set form recognised by 001 in 8:6
// - false clears byte, true sets all bits
`timescale 1ns/1ps
module ccp_main (
  input wire logic i_clk,
  input wire logic i_rst_b,
  ccp_if.main bus,
  input wire logic i_start,
  input wire ccp_pkg::ccp_word_t i_opword,
  input wire ccp_pkg::ccp_addr_t i_op_addr,
  input wire ccp_pkg::ccp_ext_tbl_t i_ext_tbl,
  input wire logic [2:0] i_ea_words,
  input wire logic i_fetch_valid,
  input wire ccp_pkg::ccp_word_t i_fetch_data,
  output logic o_fetch_req,
  output ccp_pkg::ccp_addr_t o_fetch_addr,
  output logic o_busy,
  output logic o_done,
  output logic o_taken,
  output ccp_pkg::ccp_addr_t o_next_addr,
  output logic o_byte_wr,
  output logic [7:0] o_byte_val,
  output logic o_viol
);
  import ccp_pkg::*;

  // ****************************************
  // state and datapath registers
  // ****************************************
  typedef enum logic [3:0] {
    M_IDLE, M_FETCH_SEL, M_WRITE, M_READ, M_FETCH_EXT, M_SEND_EXT,
    M_FETCH_D0, M_FETCH_D1
  } ccp_mstate_t;
  ccp_mstate_t state;
  ccp_word_t op;
  ccp_word_t sel_word;
  ccp_word_t disp_hi;
  ccp_addr_t spt;
  ccp_addr_t base;
  ccp_addr_t disp_ptr;
  logic [2:0] ea_words;

  // decode of the offered operation word
  logic line_ok;
  logic [2:0] form;
  logic start_ok;
  assign line_ok = i_opword[OP_LINE_HI:OP_LINE_LO] == OP_LINE_PAT;
  assign form = i_opword[OP_FORM_HI:OP_FORM_LO];
  assign start_ok = i_start && line_ok &&
                    (form == FORM_SET || form == FORM_BRW ||
                     form == FORM_BRL);

  // response fields, decoded combinationally from the posted word
  logic resp_ca;
  logic [5:0] resp_fn;
  logic resp_ind;
  assign resp_ca = bus.resp_data[PRIM_CA_BIT];
  assign resp_fn = bus.resp_data[PRIM_FN_HI:PRIM_FN_LO];
  assign resp_ind = bus.resp_data[PRIM_IND_BIT];

  ccp_addr_t skip_ptr;
  assign skip_ptr = base +
    {28'h000_0000, i_ext_tbl[op[OP_CODE_HI:OP_CODE_LO]], 1'b0};

  ccp_addr_t disp_w;
  assign disp_w = {{16{i_fetch_data[15]}}, i_fetch_data};

  // ****************************************
  // protocol sequence
  // ****************************************
  // one process owns sequence, pointer and interface strobes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= M_IDLE;
      op <= 16'h0000;
      sel_word <= 16'h0000;
      disp_hi <= 16'h0000;
      spt <= 32'h0000_0000;
      base <= 32'h0000_0000;
      disp_ptr <= 32'h0000_0000;
      ea_words <= 3'h0;
      o_fetch_req <= 1'b0;
      o_fetch_addr <= 32'h0000_0000;
      bus.cond_wr <= 1'b0;
      bus.cond_code <= 3'h0;
      bus.cond_data <= 16'h0000;
      bus.resp_rd <= 1'b0;
      bus.oper_wr <= 1'b0;
      bus.oper_data <= 16'h0000;
    end else begin
      bus.cond_wr <= 1'b0;
      bus.resp_rd <= 1'b0;
      bus.oper_wr <= 1'b0;
      unique case (state)
        M_IDLE: begin
          if (start_ok) begin
            op <= i_opword;
            ea_words <= i_ea_words;
            spt <= i_op_addr + WORD_BYTES;
            base <= i_op_addr + WORD_BYTES;
            bus.cond_code <= i_opword[OP_CODE_HI:OP_CODE_LO];
            sel_word <= i_opword;
            state <= (form == FORM_SET) ? M_FETCH_SEL : M_WRITE;
          end
        end
        M_FETCH_SEL: begin
          // set form: selector sits in the next stream word
          if (!o_fetch_req) begin
            o_fetch_req <= 1'b1;
            o_fetch_addr <= spt;
          end else if (i_fetch_valid) begin
            o_fetch_req <= 1'b0;
            sel_word <= i_fetch_data;
            spt <= spt + WORD_BYTES;
            base <= spt + WORD_BYTES;
            state <= M_WRITE;
          end
        end
        M_WRITE: begin
          bus.cond_wr <= 1'b1;
          bus.cond_data <= sel_word;
          state <= M_READ;
        end
        M_READ: begin
          if (bus.resp_valid && !bus.resp_rd) begin
            bus.resp_rd <= 1'b1;
            if (resp_fn == FN_NULL) begin
              spt <= skip_ptr;
              disp_ptr <= skip_ptr;
              if (op[OP_FORM_HI:OP_FORM_LO] != FORM_SET && resp_ind) begin
                state <= M_FETCH_D0;
              end else begin
                state <= M_IDLE;
              end
            end else if (ccp_has_ca(resp_fn) && !resp_ca) begin
              state <= M_IDLE;
            end else if (resp_fn == FN_XFER) begin
              state <= M_FETCH_EXT;
            end
            // other primitives: poll again
          end
        end
        M_FETCH_EXT: begin
          if (!o_fetch_req) begin
            o_fetch_req <= 1'b1;
            o_fetch_addr <= spt;
          end else if (i_fetch_valid) begin
            o_fetch_req <= 1'b0;
            bus.oper_data <= i_fetch_data;
            spt <= spt + WORD_BYTES;
            state <= M_SEND_EXT;
          end
        end
        M_SEND_EXT: begin
          bus.oper_wr <= 1'b1;
          state <= M_READ;
        end
        M_FETCH_D0: begin
          if (!o_fetch_req) begin
            o_fetch_req <= 1'b1;
            o_fetch_addr <= spt;
          end else if (i_fetch_valid) begin
            o_fetch_req <= 1'b0;
            disp_hi <= i_fetch_data;
            spt <= spt + WORD_BYTES;
            state <= (op[OP_FORM_HI:OP_FORM_LO] == FORM_BRL) ?
                     M_FETCH_D1 : M_IDLE;
          end
        end
        M_FETCH_D1: begin
          if (!o_fetch_req) begin
            o_fetch_req <= 1'b1;
            o_fetch_addr <= spt;
          end else if (i_fetch_valid) begin
            o_fetch_req <= 1'b0;
            spt <= spt + WORD_BYTES;
            state <= M_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // completion results
  // ****************************************
  // completion by main end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_taken <= 1'b0;
      o_next_addr <= 32'h0000_0000;
      o_byte_wr <= 1'b0;
      o_byte_val <= BYTE_FALSE;
      o_viol <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_byte_wr <= 1'b0;
      o_viol <= 1'b0;
      if (state == M_IDLE && start_ok) begin
        o_busy <= 1'b1;
        o_taken <= 1'b0;
      end
      if (state == M_READ && bus.resp_valid && !bus.resp_rd) begin
        if (resp_fn == FN_NULL) begin
          if (op[OP_FORM_HI:OP_FORM_LO] == FORM_SET) begin
            o_byte_wr <= 1'b1;
            o_byte_val <= resp_ind ? BYTE_TRUE : BYTE_FALSE;
            o_next_addr <= skip_ptr +
              {28'h000_0000, ea_words, 1'b0};
            o_done <= 1'b1;
            o_busy <= 1'b0;
          end else if (!resp_ind) begin
            o_next_addr <= skip_ptr +
              ((op[OP_FORM_HI:OP_FORM_LO] == FORM_BRL) ?
               LONG_BYTES : WORD_BYTES);
            o_done <= 1'b1;
            o_busy <= 1'b0;
          end
        end else if (ccp_has_ca(resp_fn) && !resp_ca) begin
          o_viol <= 1'b1;
          o_done <= 1'b1;
          o_busy <= 1'b0;
        end
      end
      if (i_fetch_valid && o_fetch_req) begin
        if (state == M_FETCH_D0 &&
            op[OP_FORM_HI:OP_FORM_LO] == FORM_BRW) begin
          o_next_addr <= disp_ptr + disp_w;
          o_taken <= 1'b1;
          o_done <= 1'b1;
          o_busy <= 1'b0;
        end else if (state == M_FETCH_D1) begin
          o_next_addr <= disp_ptr + {disp_hi, i_fetch_data};
          o_taken <= 1'b1;
          o_done <= 1'b1;
          o_busy <= 1'b0;
        end
      end
    end
  end
endmodule

// >>> tb/ccp_props.sv
// assertions on the carrier between the two conditional ends
// assumes both ends share i_clk and the active-low async reset
`timescale 1ns/1ps
module ccp_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic cond_wr,
  input wire ccp_pkg::ccp_word_t cond_data,
  input wire logic resp_rd,
  input wire logic resp_valid,
  input wire ccp_pkg::ccp_word_t resp_data,
  input wire logic oper_wr
);
  import ccp_pkg::*;
  logic [5:0] fn;
  logic pending;
  assign fn = resp_data[PRIM_FN_HI:PRIM_FN_LO];

  // open from selector write to the read that ends the exchange
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pending <= 1'b0;
    end else if (cond_wr) begin
      pending <= 1'b1;
    end else if (resp_rd && (fn == FN_NULL || fn == FN_XFER &&
                 !resp_data[PRIM_CA_BIT])) begin
      pending <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // a transfer request read with come-again set
  sequence xfer_read;
    resp_rd && fn == FN_XFER && resp_data[PRIM_CA_BIT];
  endsequence

  // ********
  // checks
  // ********
  sel_pulse_a: assert property (cond_wr |=> !cond_wr)
    else $error("selector write held too long");
  sel_format_a: assert property (cond_wr |->
    cond_data[15:12] == OP_LINE_PAT && cond_data[8:7] == 2'b01 ||
    cond_data[15:6] == 10'h000) else $error("bad condition word");
  one_open_a: assert property (cond_wr |-> !pending)
    else $error("new selector before last answer");
  read_posted_a: assert property (resp_rd |-> resp_valid && pending)
    else $error("response read with nothing posted");
  first_read_a: assert property (cond_wr |-> ##[1:60] resp_rd)
    else $error("response never read");
  serve_xfer_a: assert property (xfer_read |-> ##[1:12] oper_wr)
    else $error("transfer request not served");
  hold_open_a: assert property (
    xfer_read |=> !resp_rd until_with oper_wr)
    else $error("reread before service");
  reread_a: assert property (xfer_read |-> ##[2:60] resp_rd)
    else $error("no reread after come-again");
  come_again_a: assert property (
    resp_valid && fn == FN_XFER |-> resp_data[PRIM_CA_BIT])
    else $error("transfer posted without come-again");
  resp_hold_a: assert property (resp_valid && !resp_rd |=>
    !resp_valid || $stable(resp_data)) else $error("posted word changed");
endmodule

// >>> tb/ccp_test.sv
// self-checking bench for the main and coprocessor conditional ends
// assumes package, carrier, both ends and the checker compile first
`timescale 1ns/1ps
module test_ccp;
  import ccp_pkg::*;
  typedef struct {
    logic br;
    logic tk;
    ccp_addr_t na;
    logic [7:0] bv;
  } ccp_exp_t;
  logic i_clk = 1'b0, i_rst_b = 1'b0, start = 1'b0, start2 = 1'b0;
  logic fv = 1'b0, edone = 1'b0, etrue = 1'b0, bw_seen = 1'b0;
  logic [2:0] ext = 3'h0, ea = 3'h0;
  ccp_word_t op = 16'h0000, fdata = 16'h0000, extw;
  ccp_addr_t opa = 32'h0000_0000, faddr, naddr;
  logic freq, busy, done, taken, bwr, viol, done2, viol2, selv, extv, ereq;
  logic ok, wr;
  logic [7:0] bval;
  logic [5:0] sel;
  int errors = 0, samples_checked = 0, seed = 90;
  ccp_exp_t eq[$];
  ccp_exp_t e;
  ccp_word_t wq[$];
  ccp_word_t mem[ccp_addr_t];
  ccp_word_t bad[3] = '{16'hf215, 16'hf315, 16'he255};

  ccp_if bus ();
  ccp_if bus2 ();
  ccp_main ccp_main_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus.main),
    .i_start(start), .i_opword(op), .i_op_addr(opa), .i_ext_tbl({8{ext}}),
    .i_ea_words(ea), .i_fetch_valid(fv), .i_fetch_data(fdata),
    .o_fetch_req(freq), .o_fetch_addr(faddr), .o_busy(busy), .o_done(done),
    .o_taken(taken), .o_next_addr(naddr), .o_byte_wr(bwr),
    .o_byte_val(bval), .o_viol(viol));
  // second main end faces a far end that breaks the protocol
  ccp_main ccp_main_inst2 (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .bus(bus2.main), .i_start(start2), .i_opword(op), .i_op_addr(opa),
    .i_ext_tbl({8{ext}}), .i_ea_words(ea), .i_fetch_valid(1'b0),
    .i_fetch_data(16'h0000), .o_fetch_req(), .o_fetch_addr(), .o_busy(),
    .o_done(done2), .o_taken(), .o_next_addr(), .o_byte_wr(),
    .o_byte_val(), .o_viol(viol2));
  ccp_copro ccp_copro_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .bus(bus.copro), .i_ext_need(ext), .i_eval_done(edone),
    .i_eval_true(etrue), .o_sel_valid(selv), .o_selector(sel),
    .o_ext_valid(extv), .o_ext_word(extw), .o_eval_req(ereq));
  ccp_props ccp_props_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .cond_wr(bus.cond_wr), .cond_data(bus.cond_data), .resp_rd(bus.resp_rd),
    .resp_valid(bus.resp_valid), .resp_data(bus.resp_data),
    .oper_wr(bus.oper_wr));

  // ********
  // helpers
  // ********
  // 10 MHz clock
  always #50 i_clk = ~i_clk;

  task automatic chk(input logic good, input string m);
    samples_checked++;
    if (!good) begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // far end post: held until the read edge, then scrambled
  task automatic post(input ccp_word_t w);
    bus2.resp_valid <= 1'b1;
    bus2.resp_data <= w;
    do @(posedge i_clk); while (bus2.resp_rd !== 1'b1);
    bus2.resp_valid <= 1'b0;
    bus2.resp_data <= ~w;
  endtask

  // one instruction: lay out the stream, note results, start, wait
  task automatic run_one(input int i);
    ccp_exp_t x;
    ccp_addr_t a, p;
    ccp_word_t o;
    logic [31:0] d;
    logic [2:0] n, m;
    int k;
    n = 3'(i % 4);
    m = 3'(i / 3 % 6);
    d = (i < 3) ? 32'hffff_8000 : $random(seed);
    x.br = (i % 3 != 0);
    x.tk = (i / 3 % 2 == 0);
    x.bv = x.tk ? BYTE_TRUE : BYTE_FALSE;
    o = {OP_LINE_PAT, 3'h1, 3'(i % 3 + 1), 6'($random(seed))};
    a = {$random(seed)} & 32'h00ff_fffe;
    p = a + WORD_BYTES;
    if (!x.br) begin
      mem[p] = {10'h000, o[5:0]};
      p += WORD_BYTES;
    end
    wq.push_back({10'h000, o[5:0]});
    for (k = 0; k < n; k++) begin
      mem[p] = $random(seed);
      wq.push_back(mem[p]);
      p += WORD_BYTES;
    end
    // p now sits on the displacement or the address words
    case (i % 3)
      0: x.na = p + 32'(m) * WORD_BYTES;
      1: begin
        mem[p] = d[15:0];
        x.na = p + (x.tk ? {{16{d[15]}}, d[15:0]} : WORD_BYTES);
      end
      default: begin
        mem[p] = d[31:16];
        mem[p + WORD_BYTES] = d[15:0];
        x.na = p + (x.tk ? d : LONG_BYTES);
      end
    endcase
    eq.push_back(x);
    @(posedge i_clk);
    start <= 1'b1;
    op <= o;
    opa <= a;
    ext <= n;
    ea <= m;
    etrue <= x.tk;
    @(posedge i_clk);
    start <= 1'b0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge i_clk);
    chk(k < 300, "instruction never completed");
  endtask

  // fetch port with random latency; data scrambled outside the pulse
  always begin
    @(posedge i_clk);
    if (freq === 1'b1) begin
      repeat ({$random(seed)} % 3) @(posedge i_clk);
      fv <= 1'b1;
      fdata <= mem.exists(faddr) ? mem[faddr] : faddr[15:0];
      @(posedge i_clk);
      fv <= 1'b0;
      fdata <= ~fdata;
      @(posedge i_clk);
    end
  end

  // evaluation unit answers after a random delay
  always begin
    @(posedge i_clk);
    if (ereq === 1'b1) begin
      repeat ({$random(seed)} % 4) @(posedge i_clk);
      edone <= 1'b1;
      @(posedge i_clk);
      edone <= 1'b0;
      @(posedge i_clk);
    end
  end

  // ********
  // monitor: oldest note against each result
  // ********
  always @(posedge i_clk) begin
    if (bwr === 1'b1) begin
      bw_seen = 1'b1;
    end
    if (selv === 1'b1 || extv === 1'b1) begin
      ok = wq.size() > 0;
      if (ok) begin
        ok = wq.pop_front() ===
             (selv === 1'b1 ? {10'h000, sel} : extw);
      end
      chk(ok, "coprocessor word");
    end
    if (done === 1'b1) begin
      ok = eq.size() > 0;
      if (ok) begin
        e = eq.pop_front();
        ok = naddr === e.na && viol === 1'b0;
      end
      chk(ok, "next address");
      wr = bw_seen || bwr === 1'b1;
      ok = e.br ? taken === e.tk && !wr : wr && bval === e.bv;
      chk(ok, "completion");
      bw_seen = 1'b0;
    end
  end

  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    finish_test();
  end

  // ********
  // main sequence
  // ********
  initial begin
    int k;
    bus2.resp_valid = 1'b0;
    bus2.resp_data = 16'h0000;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (k = 0; k < 18; k++) run_one(k);
    // malformed operation words pass without any sign
    foreach (bad[j]) begin
      @(posedge i_clk);
      start <= 1'b1;
      op <= bad[j];
      @(posedge i_clk);
      start <= 1'b0;
    end
    repeat (20) @(posedge i_clk);
    chk(busy === 1'b0 && eq.size() == 0 && wq.size() == 0, "stray");
    // busy reply, then a transfer without come-again
    @(posedge i_clk);
    start2 <= 1'b1;
    op <= 16'hf2aa;
    @(posedge i_clk);
    start2 <= 1'b0;
    while (bus2.cond_wr !== 1'b1) @(posedge i_clk);
    post({2'b00, FN_BUSY, 8'h00});
    @(posedge i_clk);
    post({2'b00, FN_XFER, 8'h00});
    for (k = 0; k < 50 && done2 !== 1'b1; k++) @(posedge i_clk);
    chk(done2 === 1'b1 && viol2 === 1'b1, "no violation");
    finish_test();
  end
endmodule
